// >>> hw/gpio_bank5_6_pin_config.sv
/*
  Configuration, data and event logic for port 5 pins 1-7 and port 6 pin 0,
  reached over AHB-Lite. Assumes the pins come from outside the clock domain
  and the second serial port and LED logic run on clk_sys.
*/
`timescale 1ns/1ns
`include "gpio_pin_cfg_params.svh"

module gpio_bank5_6_pin_config
    import gpio_pin_cfg_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic                  hsel,
    input  wire logic [ADDR_WIDTH-1:0] haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [7:0]            pin_in,
    output logic      [7:0]            pin_out,
    output logic      [7:0]            pin_oe_n,
    output logic                       serial2_carrier_detect_n,
    output logic                       serial2_receive_data,
    output logic                       serial2_set_ready_n,
    output logic                       serial2_clear_send_n,
    input  wire logic                  serial2_transmit_data,
    input  wire logic                  serial2_request_send_n,
    input  wire logic                  serial2_terminal_ready_n,
    input  wire logic                  indicator_out_1,
    output logic                       irq
);

    // Event registers sit at bytes 0x200 to 0x208; fewer than ten address bits cannot reach them
    if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32)
    begin : g_addr_width_check
        $error("ADDR_WIDTH must lie between 10 and 32");
    end

    localparam int PINS = 8;
    localparam int IRQ_PIN = 7;

    cfg_byte_type              cfg_reg [PINS];
    logic [7:0]                data5_reg;
    logic [7:0]                data6_reg;
    logic [`EVT_WIDTH-1:0]     status_reg;
    logic [`EVT_WIDTH-1:0]     enable_reg;
    logic [PINS-1:0]           pin_meta_reg;
    logic [PINS-1:0]           pin_sync_reg;
    logic [PINS-1:0]           pin_prev_reg;
    logic [PINS-1:0]           logic_in;
    logic [PINS-1:0]           out_val;
    logic [PINS-1:0]           latch_val;
    logic [PINS-1:0]           drive_en;
    logic [PINS-1:0]           oe_n_next;
    logic [PINS-1:0]           out_next;
    logic [`EVT_WIDTH-1:0]     event_set;
    bus_state_type             state_reg;
    logic [ADDR_WIDTH-1:0]     addr_reg;
    logic                      wr_pend_reg;
    logic                      accept;

    function automatic logic [1:0] fsel(input cfg_byte_type c);
        fsel = c[`CFG_FSEL_MSB:`CFG_FSEL_LSB];
    endfunction : fsel

    function automatic logic is_idx(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] idx);
        is_idx = (a[1:0] == 2'h0) && (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx));
    endfunction : is_idx

    // Pin synchroniser; the second stage feeds logic, a third stage holds the previous value for edge detection
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pin_meta_reg <= 8'hFF;
            pin_sync_reg <= 8'hFF;
            pin_prev_reg <= 8'hFF;
        end
        else
        begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Latches in pin order, so no pin indexes past the end of port 5
    assign latch_val = {data6_reg[0], data5_reg[7:1]};

    // Per-pin input view, output source and driver control
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            logic_in[i] = pin_sync_reg[i] ^ cfg_reg[i][`CFG_POL_BIT];
            out_val[i] = latch_val[i];
            if (fsel(cfg_reg[i]) == `FSEL_ALT1)
            begin
                case (i)
                    2: out_val[i] = serial2_transmit_data;
                    4: out_val[i] = serial2_request_send_n;
                    6: out_val[i] = serial2_terminal_ready_n;
                    7: out_val[i] = indicator_out_1;
                    default: out_val[i] = out_val[i];
                endcase
            end
            out_val[i] = out_val[i] ^ cfg_reg[i][`CFG_POL_BIT];
            drive_en[i] = !cfg_reg[i][`CFG_DIR_BIT];
            // Open drain only pulls low; a high level is left to the pull-up
            oe_n_next[i] = !(drive_en[i] && (!cfg_reg[i][`CFG_OTYPE_BIT] || !out_val[i]));
            out_next[i] = cfg_reg[i][`CFG_OTYPE_BIT] ? 1'b0 : out_val[i];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pin_out  <= 8'h00;
            pin_oe_n <= 8'hFF;
        end
        else
        begin
            pin_out  <= out_next;
            pin_oe_n <= oe_n_next;
        end
    end

    // Serial inputs idle inactive when the pin is not routed to them
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            serial2_carrier_detect_n <= 1'b1;
            serial2_receive_data     <= 1'b1;
            serial2_set_ready_n      <= 1'b1;
            serial2_clear_send_n     <= 1'b1;
        end
        else
        begin
            serial2_carrier_detect_n <= (fsel(cfg_reg[0]) == `FSEL_ALT1) ? logic_in[0] : 1'b1;
            serial2_receive_data     <= (fsel(cfg_reg[1]) == `FSEL_ALT1) ? logic_in[1] : 1'b1;
            serial2_set_ready_n      <= (fsel(cfg_reg[3]) == `FSEL_ALT1) ? logic_in[3] : 1'b1;
            serial2_clear_send_n     <= (fsel(cfg_reg[5]) == `FSEL_ALT1) ? logic_in[5] : 1'b1;
        end
    end

    // AHB-Lite address phase; reads take one wait state so hrdata is registered
    assign accept = hsel && htrans[1] && hready;
    assign hreadyout = (state_reg != BUS_RD_WAIT);
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_reg   <= BUS_IDLE;
            addr_reg    <= '0;
            wr_pend_reg <= 1'b0;
        end
        else
        begin
            wr_pend_reg <= accept && hwrite;
            if (accept)
                addr_reg <= haddr;
            case (state_reg)
                BUS_IDLE:    state_reg <= (accept && !hwrite) ? BUS_RD_WAIT : BUS_IDLE;
                BUS_RD_WAIT: state_reg <= BUS_IDLE;
                default:     state_reg <= BUS_IDLE;
            endcase
        end
    end

    // Configuration and data registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < PINS; i++)
                cfg_reg[i] <= (i == 2) ? `CFG_RESET_TXD_PIN : `CFG_RESET_DEFAULT;
            data5_reg <= `DATA_RESET;
            data6_reg <= `DATA_RESET;
        end
        else if (wr_pend_reg)
        begin
            for (int i = 0; i < PINS; i++)
                if (is_idx(addr_reg, 8'(`IDX_PORT5_PIN1_CONFIG + i)))
                    cfg_reg[i] <= hwdata[7:0] & `CFG_WRITE_MASK;
            if (is_idx(addr_reg, `IDX_PORT5_DATA))
                data5_reg <= hwdata[7:0];
            if (is_idx(addr_reg, `IDX_PORT6_DATA))
                data6_reg <= {7'h00, hwdata[0]};
        end
    end

    // Events: either edge on the interrupt pin, change on a port 5 GPIO input
    always_comb
    begin
        event_set = '0;
        event_set[`EVT_EDGE_IRQ4] = (fsel(cfg_reg[IRQ_PIN]) == `FSEL_ALT2)
            && (pin_sync_reg[IRQ_PIN] != pin_prev_reg[IRQ_PIN]);
        for (int i = 0; i < IRQ_PIN; i++)
            if (cfg_reg[i][`CFG_DIR_BIT] && fsel(cfg_reg[i]) == `FSEL_GPIO
                && pin_sync_reg[i] != pin_prev_reg[i])
                event_set[`EVT_PORT5_CHANGE] = 1'b1;
    end

    // A set in the clearing cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            status_reg <= `EVENT_RESET;
            enable_reg <= `EVENT_RESET;
        end
        else
        begin
            if (wr_pend_reg && is_idx(addr_reg, `IDX_EVENT_ENABLE))
                enable_reg <= hwdata[`EVT_WIDTH-1:0];
            if (wr_pend_reg && is_idx(addr_reg, `IDX_EVENT_CLEAR))
                status_reg <= (status_reg & ~hwdata[`EVT_WIDTH-1:0]) | event_set;
            else
                status_reg <= status_reg | event_set;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(status_reg & enable_reg);
    end

    // Read data: input pins show their level, output pins their latch
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            hrdata <= 32'h0000_0000;
        else if (state_reg == BUS_RD_WAIT)
        begin
            hrdata <= 32'h0000_0000;
            for (int i = 0; i < PINS; i++)
                if (is_idx(addr_reg, 8'(`IDX_PORT5_PIN1_CONFIG + i)))
                    hrdata <= {24'h000000, cfg_reg[i]};
            if (is_idx(addr_reg, `IDX_PORT5_DATA))
            begin
                for (int i = 0; i < IRQ_PIN; i++)
                    hrdata[i+1] <= cfg_reg[i][`CFG_DIR_BIT] ? logic_in[i] : data5_reg[i+1];
                hrdata[0] <= data5_reg[0];
            end
            if (is_idx(addr_reg, `IDX_PORT6_DATA))
                hrdata[0] <= cfg_reg[IRQ_PIN][`CFG_DIR_BIT] ? logic_in[IRQ_PIN] : data6_reg[0];
            if (is_idx(addr_reg, `IDX_EVENT_STATUS))
                hrdata[`EVT_WIDTH-1:0] <= status_reg;
            if (is_idx(addr_reg, `IDX_EVENT_ENABLE))
                hrdata[`EVT_WIDTH-1:0] <= enable_reg;
        end
    end

    dir_input_a: assert property (@(posedge clk_sys) disable iff (srst)
        cfg_reg[0][`CFG_DIR_BIT] |=> pin_oe_n[0])
        else $error("input pin is being driven");

    polarity_a: assert property (@(posedge clk_sys) disable iff (srst)
        (!cfg_reg[1][`CFG_DIR_BIT] && !cfg_reg[1][`CFG_OTYPE_BIT]
         && fsel(cfg_reg[1]) == `FSEL_GPIO && $stable(cfg_reg[1]) && $stable(data5_reg))
        |=> pin_out[1] == ($past(data5_reg[2]) ^ $past(cfg_reg[1][`CFG_POL_BIT])))
        else $error("output polarity wrong");

    open_drain_a: assert property (@(posedge clk_sys) disable iff (srst)
        cfg_reg[3][`CFG_OTYPE_BIT] |=> !pin_out[3])
        else $error("open drain pin drives high");

    carrier_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[0]) == `FSEL_ALT1) |=> serial2_carrier_detect_n == $past(logic_in[0]))
        else $error("carrier detect not routed");

    txd_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[2]) == `FSEL_ALT1 && !cfg_reg[2][`CFG_DIR_BIT]
         && !cfg_reg[2][`CFG_OTYPE_BIT] && !cfg_reg[2][`CFG_POL_BIT])
        |=> pin_out[2] == $past(serial2_transmit_data) && !pin_oe_n[2])
        else $error("transmit data not on pin");

    edge_event_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[IRQ_PIN]) == `FSEL_ALT2 && pin_sync_reg[IRQ_PIN] != pin_prev_reg[IRQ_PIN])
        |=> status_reg[`EVT_EDGE_IRQ4] ##1 (irq == ($past(enable_reg[`EVT_EDGE_IRQ4])
            || ($past(status_reg[`EVT_PORT5_CHANGE]) && $past(enable_reg[`EVT_PORT5_CHANGE])))))
        else $error("pin edge did not raise the event");

    reset_value_a: assert property (@(posedge clk_sys)
        srst |=> cfg_reg[2] == `CFG_RESET_TXD_PIN && cfg_reg[7] == `CFG_RESET_DEFAULT
        && pin_oe_n == 8'hFF)
        else $error("configuration reset value wrong");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        (state_reg == BUS_RD_WAIT && is_idx(addr_reg, `IDX_PORT5_PIN1_CONFIG))
        |=> hrdata[6:4] == 3'h0 && hrdata[31:8] == 24'h000000 && hreadyout)
        else $error("reserved bits read non-zero");

    read_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
        (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state missing");

    write_ready_a: assert property (@(posedge clk_sys) disable iff (srst)
        (accept && hwrite) |=> hreadyout)
        else $error("write data phase stalled");

    serial_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[0]) != `FSEL_ALT1) |=> serial2_carrier_detect_n)
        else $error("unrouted carrier detect not idle");

    rxd_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[1]) == `FSEL_ALT1) |=> serial2_receive_data == $past(logic_in[1]))
        else $error("receive data not routed");

    set_ready_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[3]) == `FSEL_ALT1) |=> serial2_set_ready_n == $past(logic_in[3]))
        else $error("set ready not routed");

    clear_send_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[5]) == `FSEL_ALT1) |=> serial2_clear_send_n == $past(logic_in[5]))
        else $error("clear to send not routed");

    rts_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[4]) == `FSEL_ALT1 && !cfg_reg[4][`CFG_DIR_BIT]
         && !cfg_reg[4][`CFG_OTYPE_BIT] && !cfg_reg[4][`CFG_POL_BIT])
        |=> pin_out[4] == $past(serial2_request_send_n) && !pin_oe_n[4])
        else $error("request to send not on pin");

    dtr_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[6]) == `FSEL_ALT1 && !cfg_reg[6][`CFG_DIR_BIT]
         && !cfg_reg[6][`CFG_OTYPE_BIT] && !cfg_reg[6][`CFG_POL_BIT])
        |=> pin_out[6] == $past(serial2_terminal_ready_n) && !pin_oe_n[6])
        else $error("terminal ready not on pin");

    led_route_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[7]) == `FSEL_ALT1 && !cfg_reg[7][`CFG_DIR_BIT]
         && !cfg_reg[7][`CFG_OTYPE_BIT] && !cfg_reg[7][`CFG_POL_BIT])
        |=> pin_out[7] == $past(indicator_out_1) && !pin_oe_n[7])
        else $error("indicator not on pin");

    data_out_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[0]) == `FSEL_GPIO && !cfg_reg[0][`CFG_DIR_BIT]
         && !cfg_reg[0][`CFG_OTYPE_BIT] && !cfg_reg[0][`CFG_POL_BIT])
        |=> pin_out[0] == $past(data5_reg[1]) && !pin_oe_n[0])
        else $error("data latch not on pin");

    reserved_code_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fsel(cfg_reg[5]) == 2'h3 && !cfg_reg[5][`CFG_DIR_BIT]
         && !cfg_reg[5][`CFG_OTYPE_BIT] && !cfg_reg[5][`CFG_POL_BIT])
        |=> pin_out[5] == $past(data5_reg[6]) && !pin_oe_n[5])
        else $error("reserved code not plain output");

    status_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        (status_reg[`EVT_EDGE_IRQ4]
         && !(wr_pend_reg && is_idx(addr_reg, `IDX_EVENT_CLEAR) && hwdata[`EVT_EDGE_IRQ4]))
        |=> status_reg[`EVT_EDGE_IRQ4])
        else $error("edge event lost before clear");

    enable_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        (wr_pend_reg && is_idx(addr_reg, `IDX_EVENT_ENABLE))
        |=> enable_reg == $past(hwdata[`EVT_WIDTH-1:0]))
        else $error("enable write lost");

    cfg_reserved_a: assert property (@(posedge clk_sys) disable iff (srst)
        (wr_pend_reg && is_idx(addr_reg, `IDX_PORT5_PIN2_CONFIG))
        |=> cfg_reg[1][6:4] == 3'h0 && cfg_reg[1][3:0] == $past(hwdata[3:0]))
        else $error("reserved configuration bits stored");

endmodule : gpio_bank5_6_pin_config

// >>> hw/gpio_pin_cfg_params.svh
/*
  Offsets, field positions and reset values of the port 5/6 pin
  configuration block. Assumes a 32-bit AHB-Lite bus with word registers.
*/
`ifndef GPIO_PIN_CFG_PARAMS_SVH
`define GPIO_PIN_CFG_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_PORT5_PIN1_CONFIG   8'h40
`define IDX_PORT5_PIN2_CONFIG   8'h41
`define IDX_PORT5_PIN3_CONFIG   8'h42
`define IDX_PORT5_PIN4_CONFIG   8'h43
`define IDX_PORT5_PIN5_CONFIG   8'h44
`define IDX_PORT5_PIN6_CONFIG   8'h45
`define IDX_PORT5_PIN7_CONFIG   8'h46
`define IDX_PORT6_PIN0_CONFIG   8'h47
`define IDX_PORT5_DATA          8'h4F
`define IDX_PORT6_DATA          8'h50
`define IDX_EVENT_STATUS        8'h80
`define IDX_EVENT_ENABLE        8'h81
`define IDX_EVENT_CLEAR         8'h82

// Configuration fields
`define CFG_DIR_BIT             0
`define CFG_POL_BIT             1
`define CFG_FSEL_LSB            2
`define CFG_FSEL_MSB            3
`define CFG_OTYPE_BIT           7
`define CFG_WRITE_MASK          8'h8F

// Function select codes
`define FSEL_GPIO               2'h0
`define FSEL_ALT1               2'h1
`define FSEL_ALT2               2'h2

// Reset values
`define CFG_RESET_DEFAULT       8'h01
`define CFG_RESET_TXD_PIN       8'h00
`define DATA_RESET              8'h00
`define EVENT_RESET             2'h0

// Event status bits
`define EVT_EDGE_IRQ4           0
`define EVT_PORT5_CHANGE        1
`define EVT_WIDTH               2

`endif

// >>> hw/gpio_pin_cfg_pkg.sv
/*
  Types shared by the port 5/6 pin configuration block.
  Assumes the constants header is included alongside.
*/
package gpio_pin_cfg_pkg;

    typedef enum logic [1:0]
    {
        BUS_IDLE    = 2'h0,
        BUS_RD_WAIT = 2'h1
    } bus_state_type;

    typedef logic [7:0] cfg_byte_type;

endpackage : gpio_pin_cfg_pkg

// >>> sim/pad_model.sv
/*
  Pad model for the eight configurable pins of port 5 and port 6.
  Assumes pin_oe_n is low while the block drives a pad; a released pad
  follows the board-side driver given by ext_val.
*/
`timescale 1ns/1ns

module pad_model
(
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    // Board side only drives a pad the block has released, so no contention
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pin_in[i] = pin_oe_n[i] ? ext_val[i] : pin_out[i];
        end
    end
endmodule : pad_model

// >>> sim/tb.sv
/*
  Self-checking bench: reset values, random pin setups, routing to the
  second serial port and LED, data reads and the event interrupt.
  Assumes one 50 MHz clock and this bench as the only AHB-Lite master.
*/
`timescale 1ns/1ns

module tb
    import gpio_pin_cfg_pkg::*;
;
    logic         clk_sys;
    logic         srst;
    logic         hsel;
    logic         hwrite;
    logic         hreadyout;
    logic         hresp;
    logic         irq;
    logic         d6;
    logic [11:0]  haddr;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic [31:0]  rdat;
    logic [7:0]   pin_in;
    logic [7:0]   pin_out;
    logic [7:0]   pin_oe_n;
    logic [7:0]   ext_val;
    logic [7:0]   alt_src;
    logic [7:0]   d5;
    logic         serial2_carrier_detect_n;
    logic         serial2_receive_data;
    logic         serial2_set_ready_n;
    logic         serial2_clear_send_n;
    cfg_byte_type cfg [8];
    int           err_total;
    int           checked;
    int           p;
    int           n;

    gpio_bank5_6_pin_config i_dut
    (
        .clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe_n,
        .serial2_carrier_detect_n, .serial2_receive_data, .serial2_set_ready_n,
        .serial2_clear_send_n, .serial2_transmit_data(alt_src[2]),
        .serial2_request_send_n(alt_src[4]), .serial2_terminal_ready_n(alt_src[6]),
        .indicator_out_1(alt_src[7]), .irq
    );

    pad_model i_pads
    (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in)
    );

    task report_and_stop();
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Waits are bounded so a stuck hreadyout ends the run instead of hanging it
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'h1 && n < 40);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'h1 && n < 40);
        rdat = hrdata;
        chk(hresp, 1'h0);
        if (n >= 40)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : xfer

    function automatic logic ser_exp(input int i);
        return (cfg[i][3:2] == 2'h1) ? ext_val[i] ^ cfg[i][1] : 1'h1;
    endfunction : ser_exp

    task chk_pins();
        logic       v;
        logic       lvl;
        logic       alt;
        logic [7:0] m;
        logic [7:0] e5;
        logic       e6;
        m = 8'h01;
        e5 = d5;
        e6 = d6;
        for (int i = 0; i < 8; i++)
        begin
            alt = cfg[i][3:2] == 2'h1 && (i == 2 || i == 4 || i == 6 || i == 7);
            v = (alt ? alt_src[i] : (i < 7 ? d5[i + 1] : d6)) ^ cfg[i][1];
            if (cfg[i][0])
                chk(pin_oe_n[i], 1'h1);
            else if (cfg[i][7])
                chk({pin_out[i], pin_oe_n[i]}, {1'h0, v});
            else
                chk({pin_out[i], pin_oe_n[i]}, {v, 1'h0});
            lvl = (!cfg[i][0] && (!cfg[i][7] || !v)) ? v : ext_val[i];
            if (i == 7 && cfg[i][0])
                e6 = lvl ^ cfg[i][1];
            // Port 5 input pins set to the first alternate function have no defined data read
            if (i < 7 && !(cfg[i][0] && cfg[i][3:2] == 2'h1))
            begin
                m[i + 1] = 1'h1;
                e5[i + 1] = cfg[i][0] ? lvl ^ cfg[i][1] : d5[i + 1];
            end
        end
        xfer(1'h0, 12'h13C, 32'h0);
        chk(rdat & {24'h0, m}, {24'h0, e5 & m});
        xfer(1'h0, 12'h140, 32'h0);
        chk(rdat, {31'h0, e6});
        chk({serial2_clear_send_n, serial2_set_ready_n, serial2_receive_data,
             serial2_carrier_detect_n}, {ser_exp(5), ser_exp(3), ser_exp(1), ser_exp(0)});
    endtask : chk_pins

    initial
    begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        #400000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        cfg_byte_type c;
        srst = 1'h1;
        hsel = 1'h0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ext_val = 8'hFF;
        alt_src = 8'hFF;
        err_total = 0;
        checked = 0;
        void'($urandom(32'h86b31676));
        for (int pass = 0; pass < 2; pass++)
        begin
            srst <= 1'h1;
            repeat (10) @(posedge clk_sys);
            srst <= 1'h0;
            @(posedge clk_sys);
            chk(pin_oe_n, 8'hFF);
            chk(irq, 1'h0);
            for (int i = 0; i < 8; i++)
            begin
                xfer(1'h0, 12'h100 + 12'(4 * i), 32'h0);
                chk(rdat, (i == 2) ? 32'h0 : 32'h1);
            end
            xfer(1'h1, 12'h120, 32'hFF);
            xfer(1'h0, 12'h120, 32'h0);
            chk(rdat, 32'h0);
            if (pass == 0)
            begin
                for (int r = 0; r < 40; r++)
                begin
                    for (int i = 0; i < 8; i++)
                    begin
                        c = 8'($urandom);
                        // Input-only functions must not be set up as outputs
                        if ((c[3:2] == 2'h1 && (i == 0 || i == 1 || i == 3 || i == 5))
                            || (c[3:2] == 2'h2 && i == 7))
                            c[0] = 1'h1;
                        cfg[i] = c;
                        xfer(1'h1, 12'h100 + 12'(4 * i), {24'h0, c});
                        xfer(1'h0, 12'h100 + 12'(4 * i), 32'h0);
                        chk(rdat, {24'h0, c & 8'h8F});
                    end
                    d5 = 8'($urandom);
                    d6 = 1'($urandom);
                    ext_val <= 8'($urandom);
                    alt_src <= 8'($urandom);
                    xfer(1'h1, 12'h13C, {24'h0, d5});
                    xfer(1'h1, 12'h140, {31'h0, d6});
                    repeat (4) @(posedge clk_sys);
                    chk_pins();
                end
                for (int b = 0; b < 2; b++)
                begin
                    p = b ? 0 : 7;
                    xfer(1'h1, 12'h100 + 12'(4 * p), b ? 32'h1 : 32'h9);
                    repeat (4) @(posedge clk_sys);
                    xfer(1'h1, 12'h208, 32'h3);
                    xfer(1'h1, 12'h204, 32'(1 << b));
                    xfer(1'h0, 12'h204, 32'h0);
                    chk(rdat, 32'(1 << b));
                    chk(irq, 1'h0);
                    for (int k = 0; k < 3; k++)
                    begin
                        if (k == 2)
                            xfer(1'h1, 12'h204, 32'h0);
                        ext_val[p] <= ~ext_val[p];
                        n = 0;
                        while (irq !== 1'h1 && n < 8)
                        begin
                            @(posedge clk_sys);
                            n++;
                        end
                        chk(irq, k < 2);
                        xfer(1'h0, 12'h200, 32'h0);
                        chk(rdat[b], 1'h1);
                        xfer(1'h1, 12'h208, 32'(1 << b));
                        repeat (2) @(posedge clk_sys);
                        chk(irq, 1'h0);
                    end
                end
            end
        end
        report_and_stop();
    end
endmodule : tb
